// File: include/mmseq_pkg.sv
/*
 contents: constants and the state type for the multiphase mode
 sequencer. assumes: 125 MHz ref_clk; analog comparators outside.
*/
package mmseq_pkg;
  // ==========================================================
  // code and level encoding, 12.5 mV per step
  localparam logic [6:0] MMSEQ_OFF_CODE = 7'h7f;
  localparam logic [6:0] MMSEQ_ZERO_CODE = 7'h78;
  localparam logic [6:0] MMSEQ_TOP_LEVEL = 7'h78;
  localparam logic [6:0] MMSEQ_BOOT_LEVEL = 7'h58;
  // shutdown ramp stops at one step, 12.5 mV
  localparam logic [6:0] MMSEQ_STOP_LEVEL = 7'h01;
  localparam logic [7:0] MMSEQ_GROUND_SENSE_OFFSET_ZERO = 8'h00;
  // ==========================================================
  // timing
  localparam int MMSEQ_CLK_MHZ = 125;
  localparam int MMSEQ_SETTLE_US = 20;
  localparam int MMSEQ_SETTLE_CYC = MMSEQ_SETTLE_US * MMSEQ_CLK_MHZ;
  localparam logic [11:0] MMSEQ_SETTLE_LAST =
      12'(MMSEQ_SETTLE_CYC - 1);
  localparam logic [7:0] MMSEQ_STEP_NOM = 8'h3f;
  localparam logic [1:0] MMSEQ_QUARTER = 2'h3;
  localparam logic [1:0] MMSEQ_PHASE_ONE = 2'h0;
  localparam logic [1:0] MMSEQ_PHASE_THREE = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT_REF, ST_BOOT, ST_RUN, ST_DOWN, ST_DISCHARGE, ST_FAULT
  } mmseq_state_t;
endpackage : mmseq_pkg

// File: rtl/mmseq_sync.sv
/*
 contents: two-flop synchroniser, one per asynchronous input bit.
 assumes: single ref_clk domain, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mmseq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mmseq_sync_t;
  mmseq_sync_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : mmseq_sync
`default_nettype wire

// File: rtl/mmseq_top.sv
/*
 contents: mode and phase sequencer of a multiphase step-down core
 controller. assumes: all status inputs come from analog comparators or
 pins outside the clock domain; gate drivers and dac are outside.
*/
`timescale 1ns/1ps
`default_nettype none
module mmseq_top
  import mmseq_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // cpu side pins
  input wire logic power_down_pin,
  input wire logic deep_sleep_request,
  input wire logic power_state_hint,
  input wire logic [6:0] voltage_code_bits,
  input wire logic [7:0] ground_sense_offset,
  // configuration
  input wire logic three_phase_cfg,
  // analog status
  input wire logic ref_ready,
  input wire logic out_above_reg,
  input wire logic min_off_done,
  input wire logic on_time_done,
  input wire logic undervoltage_protect,
  input wire logic overvoltage_protect,
  input wire logic thermal_fault,
  // gate drive
  output logic [1:0] high_side_gate,
  output logic phase_one_low_gate,
  output logic phase_two_low_gate,
  output logic third_phase_drive_out,
  output logic third_phase_drive_oe,
  output logic external_driver_skip,
  output logic overlap_active,
  output logic on_time_shorten,
  // target, status
  output logic [7:0] regulation_target,
  output logic [6:0] target_level,
  output logic integrator_en,
  output logic output_discharge_node,
  output logic supply_good_out,
  output logic clock_gate_out,
  output logic clock_gate_oe,
  output logic upper_thresh_blank,
  output logic pulse_skip_mode,
  output logic fault_latched
);
  // ==========================================================
  // input synchronisers
  logic [17:0] raw_in;
  logic [17:0] syn;
  assign raw_in = {power_down_pin, deep_sleep_request, power_state_hint,
                   ref_ready, out_above_reg, min_off_done, on_time_done,
                   undervoltage_protect, overvoltage_protect, thermal_fault,
                   ground_sense_offset};
  mmseq_sync #(.W(18)) u_sync_ctl (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .d(raw_in),
    .q(syn)
  );
  logic [6:0] code_s;
  mmseq_sync #(.W(7)) u_sync_code (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .d(voltage_code_bits),
    .q(code_s)
  );
  logic pd_s, ds_s, psi_s, ref_s, above_s, moff_s, ont_s, flt_s;
  logic [7:0] ground_sense_offset_s;
  assign pd_s = syn[17];
  assign ds_s = syn[16];
  assign psi_s = syn[15];
  assign ref_s = syn[14];
  assign above_s = syn[13];
  assign moff_s = syn[12];
  assign ont_s = syn[11];
  assign flt_s = syn[10] | syn[9] | syn[8];
  assign ground_sense_offset_s = syn[7:0];

  // ==========================================================
  // state
  typedef struct packed {
    mmseq_state_t st;
    logic pd_d;
    logic fault;
    logic [6:0] code_d;
    logic [6:0] level;
    logic [7:0] slew_cnt;
    logic overlap;
    logic [1:0] last_ph;
    logic [1:0] hs;
    logic p1_low, p2_low, p3_drv, p3_oe, skip;
    logic shorten;
    logic [7:0] tgt;
    logic integ;
    logic integ_wait;
    logic [11:0] settle;
    logic disch, good, cg, cg_oe, blank, pskip;
  } mmseq_top_t;
  mmseq_top_t s_reg, s_next;

  // code to level, top codes select zero
  function automatic logic [6:0] code_level(input logic [6:0] c);
    code_level = (c >= MMSEQ_ZERO_CODE) ? 7'h00 : 7'(MMSEQ_TOP_LEVEL - c);
  endfunction

  logic [6:0] want;
  logic [1:0] nph;
  logic [1:0] nxt_ph;
  logic step_due;
  logic [7:0] step_len;
  always_comb begin
    s_next = s_reg;
    want = code_level(code_s);
    nph = (three_phase_cfg && psi_s && !ds_s) ? 2'h3 :
          (ds_s ? 2'h1 : 2'h2);
    nxt_ph = (s_reg.last_ph + 2'h1 >= nph) ? MMSEQ_PHASE_ONE :
             2'(s_reg.last_ph + 2'h1);
    // boot and shutdown ramps run at one quarter of nominal slew
    step_len = (s_reg.st == ST_BOOT || s_reg.st == ST_DOWN) ?
               {MMSEQ_STEP_NOM[5:0], MMSEQ_QUARTER} : MMSEQ_STEP_NOM;
    step_due = (s_reg.slew_cnt >= step_len);
    if (clk_en) begin
      s_next.pd_d = pd_s;
      s_next.code_d = code_s;
      s_next.slew_cnt = step_due ? 8'h00 : 8'(s_reg.slew_cnt + 8'h01);
      // fault latch, cleared only by a low pin
      // set only with the pin high, so a latched fault always parks the gates
      if (flt_s && pd_s && s_reg.st != ST_OFF) begin
        s_next.fault = 1'b1;
      end else if (!pd_s) begin
        s_next.fault = 1'b0;
      end
      case (s_reg.st)
        ST_OFF: begin
          s_next.level = 7'h00;
          if (pd_s && code_s != MMSEQ_OFF_CODE) begin
            s_next.st = ST_WAIT_REF;
          end
        end
        ST_WAIT_REF: begin
          if (ref_s) begin
            s_next.st = ST_BOOT;
          end
        end
        ST_BOOT: begin
          // ramp from zero to boot level
          if (step_due && s_reg.level < MMSEQ_BOOT_LEVEL) begin
            s_next.level = 7'(s_reg.level + 7'h01);
          end else if (s_reg.level >= MMSEQ_BOOT_LEVEL) begin
            s_next.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (step_due && s_reg.level < want) begin
            s_next.level = 7'(s_reg.level + 7'h01);
          end else if (step_due && s_reg.level > want) begin
            s_next.level = 7'(s_reg.level - 7'h01);
          end
        end
        ST_DOWN: begin
          // ramp down to one step, then discharge
          if (s_reg.level <= MMSEQ_STOP_LEVEL) begin
            s_next.st = ST_DISCHARGE;
            s_next.level = 7'h00;
          end else if (step_due) begin
            s_next.level = 7'(s_reg.level - 7'h01);
          end
        end
        ST_DISCHARGE: begin
          if (pd_s && !s_reg.pd_d) begin
            s_next.st = ST_WAIT_REF;
          end else if (pd_s && code_s != MMSEQ_OFF_CODE) begin
            s_next.st = ST_WAIT_REF;
          end
        end
        ST_FAULT: begin
          s_next.level = 7'h00;
        end
        default: begin
          s_next.st = ST_OFF;
        end
      endcase
      // pin low with nothing to ramp: low-power off
      if (!pd_s && (s_reg.st == ST_OFF || s_reg.st == ST_WAIT_REF ||
                    s_reg.st == ST_FAULT || s_reg.st == ST_DISCHARGE)) begin
        s_next.st = ST_OFF;
      end else if ((!pd_s || code_s == MMSEQ_OFF_CODE) &&
                   (s_reg.st == ST_BOOT || s_reg.st == ST_RUN)) begin
        // off code and falling pin share the shutdown ramp
        s_next.st = ST_DOWN;
      end
      // fault wins over every mode input except a low pin, which clears it
      if (s_next.fault && pd_s) begin
        s_next.st = ST_FAULT;
      end
      // pulse skipping only in deep sleep or boot
      s_next.pskip = (s_next.st == ST_RUN && ds_s) || s_next.st == ST_BOOT;
      if (s_reg.st == ST_RUN && ds_s && code_s != s_reg.code_d) begin
        s_next.integ = 1'b0;
        s_next.integ_wait = 1'b1;
        s_next.settle = 12'h000;
      end else if (s_reg.integ_wait && s_reg.level == want && above_s) begin
        if (s_reg.settle >= MMSEQ_SETTLE_LAST) begin
          s_next.integ = 1'b1;
          s_next.integ_wait = 1'b0;
        end else begin
          s_next.settle = 12'(s_reg.settle + 12'h001);
        end
      end else if (!s_reg.integ_wait) begin
        s_next.integ = (s_next.st == ST_RUN);
      end
      // low output after off-time: overlap all phases
      if (s_next.st != ST_RUN || ds_s) begin
        s_next.overlap = 1'b0;
      end else if (moff_s && !above_s) begin
        s_next.overlap = 1'b1;
      end else if (moff_s && above_s && s_reg.overlap) begin
        // leave overlap only when above regulation
        s_next.overlap = 1'b0;
        // resume after the last phase fired
        s_next.last_ph = nxt_ph;
      end
      // one third shorter on-time in overlap with three phases
      s_next.shorten = s_next.overlap && nph == 2'h3;
      if (s_next.st == ST_RUN && !s_next.overlap && ont_s) begin
        s_next.last_ph = nxt_ph;
      end
      if (s_next.st == ST_RUN) begin
        s_next.hs = s_next.overlap ? {nph != 2'h1, 1'b1} :
                    {s_next.last_ph == 2'h1 && !ds_s,
                     s_next.last_ph == 2'h0};
      end else begin
        s_next.hs = 2'b00;
      end
      // deep sleep in run turns off both phase two gates; in shutdown the phase two low gate stays on
      s_next.p1_low = (s_next.st == ST_RUN || s_next.st == ST_DOWN ||
                       s_next.st == ST_BOOT) && !s_next.hs[0];
      s_next.p2_low = (s_next.st == ST_RUN && !ds_s ||
                       s_next.st == ST_DOWN) && !s_next.hs[1];
      // hint low in run: third phase tri-stated, skip low
      s_next.p3_oe = three_phase_cfg && (s_next.st == ST_DOWN ||
                     s_next.st == ST_RUN && psi_s && !ds_s);
      s_next.p3_drv = s_next.p3_oe &&
                      (s_next.overlap || s_next.last_ph == MMSEQ_PHASE_THREE);
      // full power: skip line high, forced pwm
      s_next.skip = s_next.p3_oe;
      // target is level plus ground offset
      s_next.tgt = 8'({1'b0, s_next.level} + ground_sense_offset_s);
      s_next.disch = s_next.st == ST_DISCHARGE || s_next.st == ST_FAULT;
      s_next.good = s_next.st == ST_RUN && s_next.level == want;
      // clock gate hiz on pin low; off code drives it high
      s_next.cg_oe = pd_s;
      s_next.cg = !s_next.good;
      s_next.blank = s_next.st == ST_RUN && ds_s;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{st: ST_OFF, tgt: MMSEQ_GROUND_SENSE_OFFSET_ZERO, cg: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign high_side_gate = s_reg.hs;
  assign phase_one_low_gate = s_reg.p1_low;
  assign phase_two_low_gate = s_reg.p2_low;
  assign third_phase_drive_out = s_reg.p3_drv;
  assign third_phase_drive_oe = s_reg.p3_oe;
  assign external_driver_skip = s_reg.skip;
  assign overlap_active = s_reg.overlap;
  assign on_time_shorten = s_reg.shorten;
  assign regulation_target = s_reg.tgt;
  assign target_level = s_reg.level;
  assign integrator_en = s_reg.integ;
  assign output_discharge_node = s_reg.disch;
  assign supply_good_out = s_reg.good;
  assign clock_gate_out = s_reg.cg;
  assign clock_gate_oe = s_reg.cg_oe;
  assign upper_thresh_blank = s_reg.blank;
  assign pulse_skip_mode = s_reg.pskip;
  assign fault_latched = s_reg.fault;
endmodule : mmseq_top
`default_nettype wire

// File: sim/mmseq_asserts.sv
/* checker: port-level relations of the mode sequencer.
   assumes: bound to mmseq_top, one ref_clk domain, clk_en held high. */
`timescale 1ns/1ps
`default_nettype none
module mmseq_asserts (
  // clock, reset
  input wire logic ref_clk,
  input wire logic rstn,
  // inputs watched
  input wire logic power_down_pin,
  input wire logic overvoltage_protect,
  input wire logic three_phase_cfg,
  input wire logic [7:0] ground_sense_offset,
  // outputs watched
  input wire logic [1:0] high_side_gate,
  input wire logic phase_one_low_gate,
  input wire logic phase_two_low_gate,
  input wire logic third_phase_drive_out,
  input wire logic third_phase_drive_oe,
  input wire logic external_driver_skip,
  input wire logic overlap_active,
  input wire logic on_time_shorten,
  input wire logic [7:0] regulation_target,
  input wire logic [6:0] target_level,
  input wire logic output_discharge_node,
  input wire logic upper_thresh_blank,
  input wire logic fault_latched
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // fault latch
  a_fault_gates_off: assert property (fault_latched |->
    high_side_gate == 2'h0 && !phase_one_low_gate && !phase_two_low_gate
    && !third_phase_drive_out) else $error("gate on while faulted");
  a_fault_sets: assert property (
    $rose(overvoltage_protect) && power_down_pin |-> ##[1:6] fault_latched)
    else $error("fault latch not set");
  a_fault_holds: assert property (
    fault_latched && power_down_pin |=> fault_latched)
    else $error("fault latch dropped");
  // ==========================================================
  // gate and mode relations
  a_discharge_gates: assert property (output_discharge_node |->
    high_side_gate == 2'h0 && !phase_one_low_gate && !phase_two_low_gate)
    else $error("gate on during discharge");
  a_skip_needs_oe: assert property (
    !third_phase_drive_oe |-> !external_driver_skip)
    else $error("skip high with third phase off");
  a_blank_phase_two: assert property (upper_thresh_blank |->
    !high_side_gate[1] && !phase_two_low_gate && !third_phase_drive_oe)
    else $error("phase two or three active in deep sleep");
  a_overlap_cut: assert property (
    overlap_active |-> on_time_shorten == three_phase_cfg)
    else $error("overlap on-time cut wrong");
  a_no_cut_idle: assert property (
    !overlap_active |-> !on_time_shorten)
    else $error("on-time cut outside overlap");
  // ==========================================================
  // regulation target
  // offset passes a synchroniser, so it must sit still a while first
  a_target_sum: assert property (
    $stable(ground_sense_offset)[*8] ##0 $stable(target_level) |->
    regulation_target == 8'(target_level) + ground_sense_offset)
    else $error("target is not level plus offset");
endmodule : mmseq_asserts
bind mmseq_top mmseq_asserts mmseq_asserts_inst (.ref_clk, .rstn,
  .power_down_pin, .overvoltage_protect, .three_phase_cfg,
  .ground_sense_offset, .high_side_gate, .phase_one_low_gate,
  .phase_two_low_gate, .third_phase_drive_out, .third_phase_drive_oe,
  .external_driver_skip, .overlap_active, .on_time_shorten,
  .regulation_target, .target_level, .output_discharge_node,
  .upper_thresh_blank, .fault_latched);
`default_nettype wire

// File: sim/mmseq_cpu_model.sv
/* partner: cpu driving code and power-state pins.
   assumes: tasks called from the bench, pins change 1 ns after ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module mmseq_cpu_model (
  // clock
  input wire logic ref_clk,
  // cpu pins
  output logic power_down_pin,
  output logic deep_sleep_request,
  output logic power_state_hint,
  output logic [6:0] voltage_code_bits
);
  initial begin
    power_down_pin = 1'b0;
    deep_sleep_request = 1'b0;
    power_state_hint = 1'b1;
    voltage_code_bits = 7'h10;
  end
  // one-shot code word
  // all seven bits in one assignment, so no skew between them
  task automatic set_code(input logic [6:0] code);
    @(posedge ref_clk);
    #1 voltage_code_bits = code;
  endtask : set_code
  task automatic set_pins(input logic pd, input logic ds, input logic ph);
    @(posedge ref_clk);
    #1;
    power_down_pin = pd;
    deep_sleep_request = ds;
    power_state_hint = ph;
  endtask : set_pins
endmodule : mmseq_cpu_model
`default_nettype wire

// File: sim/mmseq_tb_top.sv
/* bench: boot, modes, overlap, code, off code, shutdown, fault.
   assumes: clk_en high, three phases unless a test says otherwise. */
`timescale 1ns/1ps
`default_nettype none
module mmseq_tb_top;
  logic ref_clk, rstn, ref_ready, out_above_reg, min_off_done;
  logic overvoltage_protect, thermal_fault, on_time_done, three_phase_cfg;
  logic third_phase_drive_out, integrator_en;
  logic [1:0] hs_before;
  logic [7:0] ground_sense_offset;
  logic power_down_pin, deep_sleep_request, power_state_hint;
  logic [6:0] voltage_code_bits, target_level;
  logic [7:0] regulation_target;
  logic [1:0] high_side_gate;
  logic phase_one_low_gate, phase_two_low_gate, third_phase_drive_oe;
  logic external_driver_skip, overlap_active, on_time_shorten;
  logic output_discharge_node, supply_good_out, clock_gate_out;
  logic clock_gate_oe, upper_thresh_blank, pulse_skip_mode, fault_latched;
  int fails, check_count;
  mmseq_cpu_model mmseq_cpu_model_inst (.ref_clk, .power_down_pin,
    .deep_sleep_request, .power_state_hint, .voltage_code_bits);
  mmseq_top mmseq_top_inst (.ref_clk, .rstn, .clk_en(1'b1),
    .power_down_pin, .deep_sleep_request, .power_state_hint,
    .voltage_code_bits, .ground_sense_offset, .three_phase_cfg,
    .ref_ready, .out_above_reg, .min_off_done, .on_time_done,
    .undervoltage_protect(1'b0), .overvoltage_protect,
    .thermal_fault, .high_side_gate, .phase_one_low_gate,
    .phase_two_low_gate, .third_phase_drive_out,
    .third_phase_drive_oe, .external_driver_skip, .overlap_active,
    .on_time_shorten, .regulation_target, .target_level,
    .integrator_en, .output_discharge_node, .supply_good_out,
    .clock_gate_out, .clock_gate_oe, .upper_thresh_blank,
    .pulse_skip_mode, .fault_latched);
  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // bounded wait: 0 good, 1 discharge, 2 level 6c
  task automatic wait_for(input int sel, input int lim);
    for (int n = 0; n < lim; n++) begin
      if (sel == 0 && supply_good_out === 1'b1) break;
      if (sel == 1 && output_discharge_node === 1'b1) break;
      if (sel == 2 && target_level === 7'h6c) break;
      @(posedge ref_clk);
    end
    step(4);
  endtask : wait_for
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ==========================================================
  // clock, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    fails = 0;
    check_count = 0;
    rstn = 1'b0;
    ref_ready = 1'b0;
    out_above_reg = 1'b1;
    min_off_done = 1'b1;
    overvoltage_protect = 1'b0;
    thermal_fault = 1'b0;
    on_time_done = 1'b1;
    three_phase_cfg = 1'b1;
    ground_sense_offset = 8'h00;
    step(16);
    rstn = 1'b1;
    check(clock_gate_out, 8'h01);
    step(8);
    check({phase_one_low_gate, phase_two_low_gate}, 8'h00);
    ground_sense_offset = 8'h02;
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b0, 1'b1);
    step(10);
    ref_ready = 1'b1;
    step(40);
    check(pulse_skip_mode, 8'h01);
    check(target_level < 7'h02, 8'h01);
    wait_for(0, 30000);
    check(target_level, 8'h68);
    check(regulation_target, 8'h6a);
    check({external_driver_skip, third_phase_drive_oe}, 8'h03);
    check(pulse_skip_mode, 8'h00);
    $display("test boot done");
    min_off_done = 1'b0;
    out_above_reg = 1'b0;
    on_time_done = 1'b0;
    step(4);
    // phase frozen: on-time comparator held low
    hs_before = high_side_gate;
    min_off_done = 1'b1;
    step(8);
    check({overlap_active, on_time_shorten}, 8'h03);
    check({high_side_gate, third_phase_drive_out}, 8'h07);
    out_above_reg = 1'b1;
    step(8);
    check(overlap_active, 8'h00);
    check(high_side_gate, {hs_before[0], hs_before == 2'b00});
    check(third_phase_drive_out, hs_before == 2'b10);
    on_time_done = 1'b1;
    three_phase_cfg = 1'b0;
    out_above_reg = 1'b0;
    step(8);
    check({overlap_active, on_time_shorten}, 8'h02);
    check(third_phase_drive_oe, 8'h00);
    out_above_reg = 1'b1;
    step(8);
    three_phase_cfg = 1'b1;
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b0, 1'b0);
    step(8);
    check({external_driver_skip, third_phase_drive_oe}, 8'h00);
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b1, 1'b1);
    step(8);
    check({pulse_skip_mode, upper_thresh_blank}, 8'h03);
    check({phase_two_low_gate, third_phase_drive_oe}, 8'h00);
    check(integrator_en, 8'h01);
    mmseq_cpu_model_inst.set_code(7'h14);
    step(6);
    check(integrator_en, 8'h00);
    step(294);
    check(target_level, 8'h64);
    step(2300);
    check(integrator_en, 8'h00);
    step(200);
    check(integrator_en, 8'h01);
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b0, 1'b1);
    step(8);
    check(external_driver_skip, 8'h01);
    $display("test modes done");
    mmseq_cpu_model_inst.set_code(7'h0c);
    wait_for(2, 1000);
    check(target_level, 8'h6c);
    ground_sense_offset = 8'h05;
    step(8);
    check(regulation_target, 8'h71);
    mmseq_cpu_model_inst.set_code(7'h7f);
    step(6);
    check(supply_good_out, 8'h00);
    wait_for(1, 30000);
    check({output_discharge_node, clock_gate_out}, 8'h03);
    check(clock_gate_oe, 8'h01);
    mmseq_cpu_model_inst.set_code(7'h50);
    wait_for(0, 30000);
    check(target_level, 8'h28);
    $display("test code done");
    mmseq_cpu_model_inst.set_pins(1'b0, 1'b0, 1'b1);
    step(6);
    check({supply_good_out, clock_gate_oe}, 8'h00);
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b0, 1'b1);
    step(10);
    overvoltage_protect = 1'b1;
    step(8);
    check(fault_latched, 8'h01);
    overvoltage_protect = 1'b0;
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b1, 1'b1);
    step(20);
    check(fault_latched, 8'h01);
    check({upper_thresh_blank, high_side_gate}, 8'h00);
    mmseq_cpu_model_inst.set_pins(1'b0, 1'b0, 1'b1);
    step(8);
    check(fault_latched, 8'h00);
    mmseq_cpu_model_inst.set_pins(1'b1, 1'b0, 1'b1);
    step(10);
    thermal_fault = 1'b1;
    step(8);
    check(fault_latched, 8'h01);
    check(output_discharge_node, 8'h01);
    thermal_fault = 1'b0;
    $display("test shutdown and fault done");
    conclude();
  end
endmodule : mmseq_tb_top
`default_nettype wire
